// *** core/sacs_pkg.sv ***
// constants for the sar converter control sequencer
package sacs_pkg;
	localparam logic [7:0] SACS_CTRL_ADDR   = 8'h00_E8;
	localparam logic [7:0] SACS_PWR_ADDR    = 8'h00_BB;
	localparam logic [7:0] SACS_CTRL_RESET  = 8'h00_00;
	localparam logic [7:0] SACS_PWR_RESET   = 8'h00_00;
	localparam int         SACS_BIT_ON      = 7;
	localparam int         SACS_BIT_BURST   = 6;
	localparam int         SACS_BIT_DONE    = 5;
	localparam int         SACS_BIT_BUSY    = 4;
	localparam int         SACS_BIT_WIN     = 3;
	localparam int         SACS_BIT_LOWBIAS = 7;
	localparam logic [2:0] SACS_SRC_SW      = 3'h0_0;
	localparam logic [2:0] SACS_SRC_T0      = 3'h0_1;
	localparam logic [2:0] SACS_SRC_T2      = 3'h0_2;
	localparam logic [2:0] SACS_SRC_T3      = 3'h0_3;
	localparam logic [5:0] SACS_CLKS_8BIT   = 6'h0_B;
	localparam logic [5:0] SACS_CLKS_10BIT  = 6'h0_D;
	localparam logic [5:0] SACS_CLKS_12BIT  = 6'h3_4;
	localparam int         SACS_CLK_MHZ     = 100;
	localparam int         SACS_TRACK_NS    = 1500;
	localparam int         SACS_TRACK12_NS  = 4800;
	localparam int         SACS_TRACK_CYC   =
		(SACS_TRACK_NS * SACS_CLK_MHZ + 999) / 1000;
	localparam int         SACS_TRACK12_CYC =
		(SACS_TRACK12_NS * SACS_CLK_MHZ + 999) / 1000;
	typedef enum logic [3:0] {
		SACS_IDLE  = 4'b0001,
		SACS_TRACK = 4'b0010,
		SACS_CONV  = 4'b0100,
		SACS_DONE  = 4'b1000
	} sacs_state_t;
endpackage

// *** core/sacs_sequencer.sv ***
// sar converter control register and conversion sequencer
// What this block does
// - writing 1 to power config top bit selects reduced bias mode.
// - conversion lasts 11, 13 or 52 sar clocks for 8, 10, 12 bits.
// - tracking lasts at least 1.5 us, or 4.8 us total in 12-bit mode.
// - enable bit 7 clear holds converter shut down outside a burst, set makes it active.
// - bit 6 selects burst operation when set, single conversion when clear.
// - done flag bit 5 set per conversion or per burst, held until cleared.
// - writing 1 to bit 4 starts a conversion only when source is 000.
// - window flag bit 3 set when result lies in window, software clears.
// - source 000 software, 001 timer 0, 010 timer 2, 011 timer 3.
// - source 1xx starts on a rising edge of the external strobe while idle; edges during a conversion are ignored.
// - control at address e8, bit addressable, every field resets to zero.
// - in burst one start runs repeat count conversions back to back.
// - in burst converter powers down after burst unless enable is set.
`timescale 1ns/10ps
module sacs_sequencer
	import sacs_pkg::*;
(
	input  wire logic       ref_clk,
	input  wire logic       rst_n,
	input  wire logic [7:0] sfr_addr,
	input  wire logic       sfr_wr,
	input  wire logic [7:0] sfr_wdata,
	input  wire logic       sfr_bit_wr,
	input  wire logic [2:0] sfr_bit_sel,
	input  wire logic       sfr_bit_val,
	output logic      [7:0] sfr_rdata,
	input  wire logic       sar_clk_en,
	input  wire logic [1:0] resolution,
	input  wire logic [6:0] repeat_count,
	input  wire logic       timer0_overflow,
	input  wire logic       timer2_overflow,
	input  wire logic       timer3_overflow,
	input  wire logic       external_convert_strobe,
	input  wire logic       result_valid,
	input  wire logic [15:0] result_value,
	input  wire logic [15:0] upper_bound,
	input  wire logic [15:0] lower_bound,
	output logic            low_bias_select,
	output logic            analog_powered,
	output logic            tracking,
	output logic            converting,
	output logic            conversion_start,
	output logic            conversion_done_flag,
	output logic            window_hit_flag
);
	import sacs_pkg::*;

	logic [7:0]   ctrl_reg, ctrl_next;
	logic [7:0]   pwr_reg, pwr_next;
	logic         strobe_reg;
	sacs_state_t  state_reg, state_next;
	logic [8:0]   count_reg, count_next;
	logic [6:0]   left_reg, left_next;
	logic         ctrl_hit, pwr_hit, sw_start, start_evt;
	logic [7:0]   ctrl_wval;
	logic         set_done, set_win, burst, enabled;
	logic [5:0]   conv_clks;
	logic [8:0]   track_cyc;

	default clocking sacs_cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);

	assign ctrl_hit = (sfr_wr || sfr_bit_wr) && sfr_addr == SACS_CTRL_ADDR;
	assign pwr_hit  = sfr_wr && sfr_addr == SACS_PWR_ADDR;
	assign burst    = ctrl_reg[SACS_BIT_BURST];
	assign enabled  = ctrl_reg[SACS_BIT_ON];

	always_comb begin
		ctrl_wval = ctrl_reg;
		ctrl_wval[SACS_BIT_BUSY] = 1'b0;
		if (sfr_bit_wr)
			ctrl_wval[sfr_bit_sel] = sfr_bit_val;
		else
			ctrl_wval = sfr_wdata;
	end

	// a write of 1 to busy under software source starts; 0 does nothing
	assign sw_start = ctrl_hit && ctrl_wval[SACS_BIT_BUSY]
		&& ctrl_reg[2:0] == SACS_SRC_SW;

	always_comb begin
		start_evt = 1'b0;
		if (ctrl_reg[2]) begin
			start_evt = external_convert_strobe && !strobe_reg;
		end else begin
			unique case (ctrl_reg[1:0])
				SACS_SRC_SW[1:0]: start_evt = sw_start;
				SACS_SRC_T0[1:0]: start_evt = timer0_overflow;
				SACS_SRC_T2[1:0]: start_evt = timer2_overflow;
				SACS_SRC_T3[1:0]: start_evt = timer3_overflow;
			endcase
		end
	end

	always_comb begin
		unique case (resolution)
			2'b00:   conv_clks = SACS_CLKS_8BIT;
			2'b10:   conv_clks = SACS_CLKS_12BIT;
			default: conv_clks = SACS_CLKS_10BIT;
		endcase
		if (resolution == 2'b10)
			track_cyc = 9'(SACS_TRACK12_CYC);
		else
			track_cyc = 9'(SACS_TRACK_CYC);
	end

	// sequencer: tracking, conversion, then repeat or finish
	always_comb begin
		state_next = state_reg;
		count_next = count_reg;
		left_next  = left_reg;
		set_done   = 1'b0;
		unique case (state_reg)
			SACS_IDLE: begin
				// burst may run with enable clear; single needs enable
				if (start_evt && (enabled || burst)) begin
					state_next = SACS_TRACK;
					count_next = track_cyc;
					left_next  = burst ? repeat_count : 7'h0_1;
				end
			end
			SACS_TRACK: begin
				if (count_reg <= 9'h0_01) begin
					state_next = SACS_CONV;
					count_next = {3'b000, conv_clks};
				end else begin
					count_next = count_reg - 9'h0_01;
				end
			end
			SACS_CONV: begin
				if (sar_clk_en) begin
					if (count_reg <= 9'h0_01)
						state_next = SACS_DONE;
					else
						count_next = count_reg - 9'h0_01;
				end
			end
			SACS_DONE: begin
				if (left_reg > 7'h0_01) begin
					left_next  = left_reg - 7'h0_01;
					state_next = SACS_TRACK;
					count_next = track_cyc;
				end else begin
					set_done   = 1'b1;
					state_next = SACS_IDLE;
				end
			end
			default: state_next = SACS_IDLE;
		endcase
	end

	assign set_win = result_valid && result_value > upper_bound
		&& result_value < lower_bound;

	// flags: hardware set wins over a software clear
	always_comb begin
		ctrl_next = ctrl_reg;
		if (ctrl_hit)
			ctrl_next = ctrl_wval;
		ctrl_next[SACS_BIT_BUSY] = state_next != SACS_IDLE;
		if (set_done)
			ctrl_next[SACS_BIT_DONE] = 1'b1;
		if (set_win)
			ctrl_next[SACS_BIT_WIN] = 1'b1;
		pwr_next = pwr_reg;
		if (pwr_hit)
			pwr_next = sfr_wdata;
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_reg   <= SACS_CTRL_RESET;
			pwr_reg    <= SACS_PWR_RESET;
			strobe_reg <= 1'b0;
			state_reg  <= SACS_IDLE;
			count_reg  <= 9'h0_00;
			left_reg   <= 7'h0_00;
		end else begin
			ctrl_reg   <= ctrl_next;
			pwr_reg    <= pwr_next;
			strobe_reg <= external_convert_strobe;
			state_reg  <= state_next;
			count_reg  <= count_next;
			left_reg   <= left_next;
		end
	end

	always_comb begin
		sfr_rdata = 8'h0_0;
		if (sfr_addr == SACS_CTRL_ADDR)
			sfr_rdata = ctrl_reg;
		else if (sfr_addr == SACS_PWR_ADDR)
			sfr_rdata = pwr_reg;
	end

	assign low_bias_select      = pwr_reg[SACS_BIT_LOWBIAS];
	// burst idle power follows enable
	assign analog_powered       = enabled || state_reg != SACS_IDLE;
	assign tracking             = state_reg == SACS_TRACK;
	assign converting           = state_reg == SACS_CONV;
	assign conversion_start     = state_reg == SACS_IDLE && state_next
		== SACS_TRACK;
	assign conversion_done_flag = ctrl_reg[SACS_BIT_DONE];
	assign window_hit_flag      = ctrl_reg[SACS_BIT_WIN];

	// tracking holds for at least the first stretch after a start
	sequence s_track_hold;
		tracking [*8];
	endsequence

	a_done_sticky: assert property
		(set_done |=> conversion_done_flag)
		else $error("done flag not set");
	a_win_sticky: assert property
		(set_win |=> window_hit_flag)
		else $error("window flag not set");
	a_sw_gate: assert property
		((sw_start && state_reg == SACS_IDLE && enabled) |=> tracking)
		else $error("software start lost");
	a_off_idle: assert property
		((state_reg == SACS_IDLE && !enabled && !burst) |=> !tracking)
		else $error("started while disabled");
	a_track_min: assert property
		((conversion_start && resolution != 2'b10) |=> s_track_hold)
		else $error("tracking too short");
	a_no_restart: assert property
		((converting && !sar_clk_en) |=> converting)
		else $error("conversion disturbed");
	a_low_bias: assert property
		((pwr_hit && sfr_wdata[SACS_BIT_LOWBIAS]) |=> low_bias_select)
		else $error("low bias not selected");
	a_strobe_edge: assert property
		((ctrl_reg[2] && state_reg == SACS_IDLE && enabled
		&& external_convert_strobe && !strobe_reg) |=> tracking)
		else $error("strobe edge missed");
endmodule

// *** dv/sacs_sequencer_tb.sv ***
// self-checking testbench for the sar converter control sequencer
`timescale 1ns/10ps
module sacs_sequencer_tb;
	import sacs_pkg::*;
	logic        ref_clk, rst_n, sfr_wr, sfr_bit_wr, sfr_bit_val;
	logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata;
	logic [2:0]  sfr_bit_sel;
	logic        sar_clk_en, result_valid, cv_d;
	logic [1:0]  resolution;
	logic [6:0]  repeat_count;
	logic        timer0_overflow, timer2_overflow, timer3_overflow;
	logic        external_convert_strobe;
	logic [15:0] result_value, upper_bound, lower_bound;
	logic        low_bias_select, analog_powered, tracking, converting;
	logic        conversion_start, conversion_done_flag, window_hit_flag;
	int          bad_count, tests_run, cyc, trk, cnv, st;
	sacs_sequencer sacs_sequencer_i (.ref_clk, .rst_n, .sfr_addr, .sfr_wr,
		.sfr_wdata, .sfr_bit_wr, .sfr_bit_sel, .sfr_bit_val, .sfr_rdata,
		.sar_clk_en, .resolution, .repeat_count, .timer0_overflow,
		.timer2_overflow, .timer3_overflow, .external_convert_strobe,
		.result_valid, .result_value, .upper_bound, .lower_bound,
		.low_bias_select, .analog_powered, .tracking, .converting,
		.conversion_start, .conversion_done_flag, .window_hit_flag);
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	task stop_test();
		$display("comparisons %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// activity counters, result pulse and hang guard
	always @(posedge ref_clk) begin
		cyc++;
		if (tracking === 1'b1) trk++;
		if (converting === 1'b1 && sar_clk_en === 1'b1) cnv++;
		if (conversion_start === 1'b1) st++;
		sar_clk_en <= ~sar_clk_en;
		cv_d <= converting;
		result_valid <= converting & ~cv_d;
		if (cyc == 20000) begin
			bad_count++;
			stop_test();
		end
	end
	task chk(input logic ok, input string m);
		tests_run++;
		if (ok !== 1'b1) begin
			bad_count++;
			$display("MISMATCH %0t %s", $time, m);
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		sfr_addr <= a;
		sfr_wdata <= d;
		sfr_wr <= 1'b1;
		@(posedge ref_clk);
		sfr_wr <= 1'b0;
		#1;
	endtask
	task bw(input logic [2:0] s, input logic v);
		@(posedge ref_clk);
		sfr_addr <= SACS_CTRL_ADDR;
		sfr_bit_sel <= s;
		sfr_bit_val <= v;
		sfr_bit_wr <= 1'b1;
		@(posedge ref_clk);
		sfr_bit_wr <= 1'b0;
		#1;
	endtask
	task rd(input logic [7:0] a, input logic [7:0] e, input string m);
		@(posedge ref_clk);
		sfr_addr <= a;
		#1;
		if (sfr_rdata !== e) begin
			bad_count++;
			$display("MISMATCH %0t read %s", $time, m);
		end
		tests_run++;
	endtask
	task wait_done();
		int n;
		n = 0;
		while (conversion_done_flag !== 1'b1 && n < 3000) begin
			@(posedge ref_clk);
			n++;
		end
		#1;
		if (conversion_done_flag !== 1'b1) begin
			bad_count++;
			$display("MISMATCH %0t done flag timeout", $time);
		end
	endtask
	task t_sw(input logic [1:0] r, input int clks, input int tmin,
			input logic win);
		int t0, c0;
		@(posedge ref_clk);
		resolution <= r;
		t0 = trk;
		c0 = cnv;
		wr(SACS_CTRL_ADDR, 8'h00_90);
		rd(SACS_CTRL_ADDR, 8'h00_90, "busy while running");
		wait_done();
		chk(conversion_done_flag === 1'b1, "done flag");
		chk(cnv - c0 == clks, "conversion clocks");
		chk(trk - t0 >= tmin, "tracking time");
		chk(window_hit_flag === win, "window flag");
		wr(SACS_CTRL_ADDR, 8'h00_80);
		chk(conversion_done_flag === 1'b0, "flag clear");
		chk(window_hit_flag === 1'b0, "window clear");
	endtask
	task t_src();
		int s0;
		s0 = st;
		bw(3'h4, 1'b0);
		wr(SACS_CTRL_ADDR, 8'h00_00);
		chk(analog_powered === 1'b0, "disabled again");
		wr(SACS_CTRL_ADDR, 8'h00_10);
		wr(SACS_CTRL_ADDR, 8'h00_81);
		wr(SACS_CTRL_ADDR, 8'h00_91);
		repeat (20) @(posedge ref_clk);
		chk(st == s0, "refused start");
		for (int s = 1; s < 5; s++) begin
			s0 = st;
			wr(SACS_CTRL_ADDR, 8'h00_80 | 8'(s));
			repeat (2) begin
				@(posedge ref_clk);
				timer0_overflow <= (s == 1);
				timer2_overflow <= (s == 2);
				timer3_overflow <= (s == 3);
				external_convert_strobe <= (s == 4);
				@(posedge ref_clk);
				{timer0_overflow, timer2_overflow} <= 2'h0;
				{timer3_overflow, external_convert_strobe} <= 2'h0;
				repeat (10) @(posedge ref_clk);
			end
			wait_done();
			chk(st - s0 == 1, "source start");
			wr(SACS_CTRL_ADDR, 8'h00_80);
		end
	endtask
	task t_burst();
		int s0, c0, t0;
		@(posedge ref_clk);
		s0 = st;
		c0 = cnv;
		t0 = trk;
		repeat_count <= 7'h0_3;
		resolution <= 2'h0;
		wr(SACS_CTRL_ADDR, 8'h00_40);
		wr(SACS_CTRL_ADDR, 8'h00_50);
		wait_done();
		chk(st - s0 == 1, "one start per burst");
		chk(cnv - c0 == 33, "burst clocks");
		chk(trk - t0 >= 3 * SACS_TRACK_CYC, "burst tracking");
		chk(analog_powered === 1'b0, "burst power down");
		wr(SACS_CTRL_ADDR, 8'h00_D0);
		wait_done();
		chk(analog_powered === 1'b1, "burst stays on");
	endtask
	initial begin
		{rst_n, sfr_wr, sfr_bit_wr, sfr_bit_val, result_valid} = 5'h00;
		{sfr_addr, sfr_wdata, sfr_bit_sel, repeat_count} = 26'h000_0000;
		{timer0_overflow, timer2_overflow, timer3_overflow} = 3'h0;
		{external_convert_strobe, resolution, cv_d} = 4'h0;
		{result_value, upper_bound, lower_bound} = 48'h0000_0000_0200;
		sar_clk_en = 1'b1;
		{bad_count, tests_run, cyc, trk, cnv, st} = '0;
		repeat (6) @(posedge ref_clk);
		rst_n <= 1'b1;
		rd(SACS_CTRL_ADDR, SACS_CTRL_RESET, "ctrl reset");
		rd(SACS_PWR_ADDR, SACS_PWR_RESET, "pwr reset");
		rd(8'h00_E9, 8'h00_00, "unmapped");
		chk(analog_powered === 1'b0, "shutdown");
		wr(SACS_PWR_ADDR, 8'h00_80);
		chk(low_bias_select === 1'b1, "low bias");
		bw(3'h7, 1'b1);
		rd(SACS_CTRL_ADDR, 8'h00_80, "bit write");
		chk(analog_powered === 1'b1, "enabled");
		@(posedge ref_clk);
		result_value <= 16'h0200;
		t_sw(2'h0, 11, SACS_TRACK_CYC, 1'b0);
		t_sw(2'h2, 52, SACS_TRACK12_CYC, 1'b0);
		@(posedge ref_clk);
		{upper_bound, lower_bound, result_value} <= 48'h0010_0100_0080;
		t_sw(2'h1, 13, SACS_TRACK_CYC, 1'b1);
		t_src();
		t_burst();
		stop_test();
	end
endmodule
